// File: rtl/fch_consts.svh
// constants of the flash command host: timing, op codes, register map
// Operation
// - host only sends listed command codes; code zero and unlisted ones never leave.
// - array-read code returns the device from any other mode to array reading; the model in erase setup takes it as a failed confirm, in write setup as data.
// - read-status code makes reads return the status byte.
// - erase is setup code then confirm code in the very next cycle.
// - write is setup code then address and data in the very next cycle.
// - bit seven is ready; poll it before trusting write and erase results.
// - command goes on low data lines, oe high, ce and we low; latched on rise.
`ifndef FCH_CONSTS_SVH
`define FCH_CONSTS_SVH

// timing, printed figures in ns and derived cycle counts at 50 MHz
`define FCH_CLK_NS 20
`define FCH_CYC(ns) ((((ns) + `FCH_CLK_NS - 1) / `FCH_CLK_NS))
`define FCH_STROBE_NS 70
`define FCH_ACCESS_NS 80
`define FCH_RECOVER_NS 20
`define FCH_RESET_NS 100
`define FCH_STROBE_CYC 4'(`FCH_CYC(`FCH_STROBE_NS))
`define FCH_ACCESS_CYC 4'(`FCH_CYC(`FCH_ACCESS_NS))
`define FCH_RECOVER_CYC 4'(`FCH_CYC(`FCH_RECOVER_NS))
`define FCH_RESET_CYC 4'(`FCH_CYC(`FCH_RESET_NS))

// device command codes
`define FCH_CODE_READ_ARRAY 8'hff
`define FCH_CODE_IDENTIFY 8'h90
`define FCH_CODE_READ_STATUS 8'h70
`define FCH_CODE_CLEAR_STATUS 8'h50
`define FCH_CODE_ERASE_SETUP 8'h20
`define FCH_CODE_ERASE_GO 8'hd0
`define FCH_CODE_WRITE_SETUP 8'h40
`define FCH_CODE_SUSPEND 8'hb0

// status byte fields
`define FCH_SR_READY 7
`define FCH_SR_SUSPEND 6
`define FCH_SR_ERASE_ERR 5
`define FCH_SR_WRITE_ERR 4
`define FCH_SR_SUPPLY_ERR 3
`define FCH_SR_RESET 8'h00

// own register map, byte addresses
`define FCH_REG_CTRL 4'h0
`define FCH_REG_ADDR 4'h4
`define FCH_REG_WDATA 4'h8
`define FCH_REG_STATUS 4'hc
`define FCH_RESP_OKAY 2'h0
`define FCH_RESP_SLVERR 2'h2

// stage codes of one sequence
`define FCH_STG_FIRST 2'h0
`define FCH_STG_SECOND 2'h1
`define FCH_STG_POLL 2'h2
`define FCH_STG_DONE 2'h3

`endif

// File: rtl/fch_pkg.sv
// types of the flash command host
package fch_pkg;
  // operations software may order through the control register
  typedef enum logic [3:0] {
    FCH_OP_READ_ARRAY = 4'h0,
    FCH_OP_IDENTIFY = 4'h1,
    FCH_OP_READ_STATUS = 4'h2,
    FCH_OP_CLEAR = 4'h3,
    FCH_OP_ERASE = 4'h4,
    FCH_OP_WRITE = 4'h5,
    FCH_OP_SUSPEND = 4'h6,
    FCH_OP_RESUME = 4'h7,
    FCH_OP_READ = 4'h8,
    FCH_OP_RESET = 4'h9
  } fch_op_type;

  typedef enum logic [4:0] {
    FCH_ST_IDLE = 5'h01,
    FCH_ST_ASSERT = 5'h02,
    FCH_ST_RELEASE = 5'h04,
    FCH_ST_RECOVER = 5'h08,
    FCH_ST_RSTPULSE = 5'h10
  } fch_state_type;

  // second bus cycle of a sequence
  typedef enum logic [1:0] {
    FCH_C2_NONE = 2'h0,
    FCH_C2_READ = 2'h1,
    FCH_C2_CODE = 2'h2,
    FCH_C2_DATA = 2'h3
  } fch_c2_type;

  typedef struct packed {
    logic c1_en;
    logic [7:0] c1;
    fch_c2_type c2;
    logic [7:0] c2_code;
    logic poll;
  } fch_plan_type;

  // pins driven toward the flash device
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rp_n;
  } fch_pins_type;

  typedef struct packed {
    logic [3:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [3:0] araddr;
    logic arvalid;
    logic rready;
  } fch_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } fch_axi_rsp_type;
endpackage

// File: rtl/fch_host.sv
// flash command host: AXI4-Lite registers in, flash bus cycles out
`timescale 1ns/10ps
`include "fch_consts.svh"
module fch_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fch_pkg::fch_axi_req_type axi_req,
  output fch_pkg::fch_axi_rsp_type axi_rsp,
  input wire logic [7:0] flash_dq_i,
  output fch_pkg::fch_pins_type flash_pins
);
  import fch_pkg::*;

  fch_state_type state_q;
  fch_plan_type plan_q;
  // response channels as separate flops, one process each side
  logic awready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rword_q;
  logic [1:0] rresp_q;
  fch_pins_type pins_q;
  logic [1:0] stage_q;
  logic [3:0] cnt_q;
  logic [19:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] sr_q;
  logic refused_q;
  logic busy_q;
  logic cur_rd_q;
  logic go;
  logic bad;
  logic wr_take;
  fch_op_type op_d;
  fch_plan_type plan_d;

  // ==========================================================
  // sequence planning
  // ==========================================================
  // only listed codes can ever be built here
  function automatic fch_plan_type plan_of(input fch_op_type op);
    fch_plan_type p;
    p = '{c1_en: 1'b1, c1: `FCH_CODE_READ_ARRAY, c2: FCH_C2_NONE,
          c2_code: `FCH_CODE_READ_ARRAY, poll: 1'b0};
    unique case (op)
      FCH_OP_READ_ARRAY: p.c1 = `FCH_CODE_READ_ARRAY;
      FCH_OP_IDENTIFY: begin
        p.c1 = `FCH_CODE_IDENTIFY;
        p.c2 = FCH_C2_READ;
      end
      FCH_OP_READ_STATUS: begin
        p.c1 = `FCH_CODE_READ_STATUS;
        p.c2 = FCH_C2_READ;
      end
      FCH_OP_CLEAR: p.c1 = `FCH_CODE_CLEAR_STATUS;
      FCH_OP_ERASE: begin
        p.c1 = `FCH_CODE_ERASE_SETUP;
        p.c2 = FCH_C2_CODE;
        p.c2_code = `FCH_CODE_ERASE_GO;
        p.poll = 1'b1;
      end
      FCH_OP_WRITE: begin
        p.c1 = `FCH_CODE_WRITE_SETUP;
        p.c2 = FCH_C2_DATA;
        p.poll = 1'b1;
      end
      FCH_OP_SUSPEND: begin
        p.c1 = `FCH_CODE_SUSPEND;
        p.poll = 1'b1; // wait for the ready bit only
      end
      FCH_OP_RESUME: p.c1 = `FCH_CODE_ERASE_GO;
      FCH_OP_READ: begin
        p.c1_en = 1'b0; // array read needs no repeated command
        p.c2 = FCH_C2_READ;
      end
      default: p.c1_en = 1'b0; // reset pulse, no bus cycle
    endcase
    return p;
  endfunction

  // stage after the one just finished
  function automatic logic [1:0] next_stage(input fch_plan_type p, input logic [1:0] stg,
                                            input logic ready);
    logic [1:0] n;
    n = `FCH_STG_DONE;
    if (stg == `FCH_STG_FIRST && p.c2 != FCH_C2_NONE) begin
      n = `FCH_STG_SECOND;
    end else if (stg != `FCH_STG_POLL && p.poll) begin
      n = `FCH_STG_POLL;
    end else if (stg == `FCH_STG_POLL && !ready) begin
      n = `FCH_STG_POLL; // busy: result bits not yet valid
    end
    return n;
  endfunction

  function automatic logic is_read(input fch_plan_type p, input logic [1:0] stg);
    return (stg == `FCH_STG_POLL) || (stg == `FCH_STG_SECOND && p.c2 == FCH_C2_READ);
  endfunction

  function automatic logic [7:0] byte_of(input fch_plan_type p, input logic [1:0] stg,
                                         input logic [7:0] wd);
    logic [7:0] b;
    b = p.c1;
    if (stg == `FCH_STG_SECOND) begin
      b = (p.c2 == FCH_C2_DATA) ? wd : p.c2_code;
    end
    return b;
  endfunction

  // ==========================================================
  // register bus
  // ==========================================================
  assign wr_take = axi_req.awvalid && axi_req.wvalid && !bvalid_q && !awready_q;
  assign op_d = fch_op_type'(axi_req.wdata[3:0]);
  assign plan_d = plan_of(op_d);
  // unknown ops, busy host, or write/erase while supply bit is set
  assign bad = busy_q || (axi_req.wdata[3:0] > 4'h9) ||
               ((op_d == FCH_OP_ERASE || op_d == FCH_OP_WRITE) && sr_q[`FCH_SR_SUPPLY_ERR]);
  assign go = wr_take && axi_req.awaddr == `FCH_REG_CTRL && axi_req.wstrb[0] && !bad;

  // write channel: address and data taken together, one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `FCH_RESP_OKAY;
    end else begin
      awready_q <= wr_take; // wready shares this flop
      if (wr_take) begin
        bvalid_q <= 1'b1;
        bresp_q <= (axi_req.awaddr == `FCH_REG_STATUS ||
                    axi_req.awaddr[1:0] != 2'h0) ? `FCH_RESP_SLVERR : `FCH_RESP_OKAY;
      end else if (axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // address and data registers, low byte lanes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 20'h00000;
      wdata_q <= 8'h00;
    end else if (wr_take && !busy_q) begin
      if (axi_req.awaddr == `FCH_REG_ADDR) begin
        if (axi_req.wstrb[0]) addr_q[7:0] <= axi_req.wdata[7:0];
        if (axi_req.wstrb[1]) addr_q[15:8] <= axi_req.wdata[15:8];
        if (axi_req.wstrb[2]) addr_q[19:16] <= axi_req.wdata[19:16];
      end
      if (axi_req.awaddr == `FCH_REG_WDATA && axi_req.wstrb[0]) begin
        wdata_q <= axi_req.wdata[7:0];
      end
    end
  end

  // refusal flag: set by a refused order, cleared by an accepted one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_q <= 1'b0;
    end else if (wr_take && axi_req.awaddr == `FCH_REG_CTRL) begin
      refused_q <= bad || !axi_req.wstrb[0];
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rword_q <= 32'h00000000;
      rresp_q <= `FCH_RESP_OKAY;
    end else begin
      arready_q <= axi_req.arvalid && !rvalid_q && !arready_q;
      if (axi_req.arvalid && !rvalid_q && !arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= `FCH_RESP_OKAY;
        unique case (axi_req.araddr)
          `FCH_REG_CTRL: rword_q <= {28'h0000000, plan_q.c1_en, 3'h0};
          `FCH_REG_ADDR: rword_q <= {12'h000, addr_q};
          `FCH_REG_WDATA: rword_q <= {24'h000000, wdata_q};
          // reserved status bits are passed raw, not interpreted
          `FCH_REG_STATUS: rword_q <= {8'h00, rdata_q, sr_q, 6'h00, refused_q, busy_q};
          default: begin
            rword_q <= 32'h00000000;
            rresp_q <= `FCH_RESP_SLVERR;
          end
        endcase
      end else if (axi_req.rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flash bus sequencer
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FCH_ST_IDLE;
      plan_q <= '0;
      stage_q <= `FCH_STG_FIRST;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      cur_rd_q <= 1'b0;
      pins_q <= '{addr: 20'h00000, dq_o: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                  we_n: 1'b1, oe_n: 1'b1, rp_n: 1'b1};
    end else begin
      unique case (state_q)
        FCH_ST_IDLE: begin
          if (go && op_d == FCH_OP_RESET) begin
            busy_q <= 1'b1;
            pins_q.rp_n <= 1'b0; // clears device status, back to array read
            cnt_q <= `FCH_RESET_CYC;
            state_q <= FCH_ST_RSTPULSE;
          end else if (go) begin
            busy_q <= 1'b1;
            plan_q <= plan_d;
            stage_q <= plan_d.c1_en ? `FCH_STG_FIRST : `FCH_STG_SECOND;
            cnt_q <= 4'h0;
            state_q <= FCH_ST_RECOVER;
          end
        end
        FCH_ST_ASSERT: begin
          // read: data sampled at the end of the access window
          if (cnt_q == 4'h1 && cur_rd_q) begin
            state_q <= FCH_ST_RELEASE;
          end else if (cnt_q == 4'h1) begin
            pins_q.we_n <= 1'b1; // we rises first, command latched here
            state_q <= FCH_ST_RELEASE;
          end
          cnt_q <= cnt_q - 4'h1;
        end
        FCH_ST_RELEASE: begin
          // ce and oe rise every read, so frozen status refreshes next poll
          pins_q.ce_n <= 1'b1;
          pins_q.oe_n <= 1'b1;
          pins_q.dq_oe <= 1'b0;
          cnt_q <= `FCH_RECOVER_CYC;
          stage_q <= next_stage(plan_q, stage_q, flash_dq_i[`FCH_SR_READY]);
          state_q <= FCH_ST_RECOVER;
        end
        FCH_ST_RECOVER: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (stage_q == `FCH_STG_DONE) begin
            busy_q <= 1'b0;
            state_q <= FCH_ST_IDLE;
          end else begin
            // address held stable over both cycles of a sequence
            cur_rd_q <= is_read(plan_q, stage_q);
            pins_q.addr <= addr_q;
            pins_q.ce_n <= 1'b0;
            pins_q.oe_n <= !is_read(plan_q, stage_q);
            pins_q.we_n <= is_read(plan_q, stage_q);
            pins_q.dq_oe <= !is_read(plan_q, stage_q); // oe stays high while driving
            pins_q.dq_o <= byte_of(plan_q, stage_q, wdata_q);
            cnt_q <= is_read(plan_q, stage_q) ? `FCH_ACCESS_CYC : `FCH_STROBE_CYC;
            state_q <= FCH_ST_ASSERT;
          end
        end
        FCH_ST_RSTPULSE: begin
          if (cnt_q == 4'h1) begin
            pins_q.rp_n <= 1'b1;
            cnt_q <= `FCH_RECOVER_CYC;
            stage_q <= `FCH_STG_DONE;
            state_q <= FCH_ST_RECOVER;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // captured read data and the host's copy of the device status byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
      sr_q <= `FCH_SR_RESET;
    end else if (state_q == FCH_ST_RELEASE && cur_rd_q) begin
      rdata_q <= flash_dq_i;
      // every poll and status read refreshes the copy; error bits are the
      // device's own sticky ones, so the copy needs no merging
      if (stage_q == `FCH_STG_POLL || plan_q.c1 == `FCH_CODE_READ_STATUS) begin
        sr_q <= flash_dq_i; // failed confirm shows bits four and five here
      end
    end else if (go && op_d == FCH_OP_CLEAR) begin
      sr_q[`FCH_SR_ERASE_ERR:`FCH_SR_SUPPLY_ERR] <= 3'h0;
    end else if (go && op_d == FCH_OP_RESET) begin
      sr_q <= `FCH_SR_RESET;
    end
  end

  // device stays in status mode after erase, write, suspend; reads still see it
  // response word gathered from the channel flops, no logic in between
  assign axi_rsp = '{awready: awready_q, wready: awready_q, bresp: bresp_q,
                     bvalid: bvalid_q, arready: arready_q, rdata: rword_q,
                     rresp: rresp_q, rvalid: rvalid_q};
  assign flash_pins = pins_q;
endmodule // fch_host

// File: verif/fch_flash_model.sv
// behavioural flash device: command decode, status byte, read data
`timescale 1ns/10ps
`include "fch_consts.svh"
module fch_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h2d, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3c // arbitrary value
) (
  input wire fch_pkg::fch_pins_type pins,
  output logic [7:0] dq
);
  import fch_pkg::*;
  typedef enum logic [2:0] {FM_ARRAY, FM_ID, FM_STAT, FM_ESET, FM_WSET} fch_fm_mode_type;
  fch_fm_mode_type mode = FM_ARRAY;
  logic [7:0] sr = 8'h80;
  logic [7:0] held = 8'h80;
  logic [7:0] last = 8'h00;
  logic [2:0] rsv = 3'h0;
  logic fail_next = 1'b0;
  logic supply_ok = 1'b1;
  int busy_ns = 300;
  wire wr_on = !pins.ce_n && !pins.we_n;
  wire rd_on = !pins.ce_n && !pins.oe_n && pins.we_n;
  // ==========
  // sequencer and command decode
  // runs inline, so commands sent while busy are never seen
  task automatic run(input int eb);
    sr[7] = 1'b0;
    sr[3] = sr[3] | !supply_ok;
    #(busy_ns);
    sr[eb] = sr[eb] | fail_next;
    fail_next = 1'b0;
    sr[7] = 1'b1;
  endtask
  // latch on the end of the strobe pair
  always @(negedge wr_on) begin
    if (sr[6] && !(pins.dq_o inside {`FCH_CODE_READ_ARRAY, `FCH_CODE_READ_STATUS,
                                     `FCH_CODE_ERASE_GO})) begin
      // suspended: anything else is dropped, state untouched
    end else if (mode == FM_ESET && pins.dq_o != `FCH_CODE_ERASE_GO) begin
      sr[5:4] = 2'b11;
      mode = FM_STAT;
    end else if (mode == FM_ESET || mode == FM_WSET) begin
      if (!sr[3]) run(mode == FM_ESET ? 5 : 4);
      mode = FM_STAT;
    end else case (pins.dq_o)
      `FCH_CODE_READ_ARRAY: mode = FM_ARRAY;
      `FCH_CODE_IDENTIFY: mode = FM_ID;
      `FCH_CODE_READ_STATUS: mode = FM_STAT;
      `FCH_CODE_CLEAR_STATUS: sr[5:3] = 3'h0;
      `FCH_CODE_ERASE_SETUP: mode = FM_ESET;
      `FCH_CODE_WRITE_SETUP, 8'h10: mode = FM_WSET;
      `FCH_CODE_ERASE_GO: if (sr[6]) begin
        sr[6] = 1'b0; // resume
        mode = FM_STAT;
      end
      // inline sequencer is never mid-erase here, so suspend halts at once
      `FCH_CODE_SUSPEND: begin
        sr[7:6] = 2'b11;
        mode = FM_STAT;
      end
      default: ; // unlisted codes have no effect
    endcase
  end
  // reset pin low: status byte and mode to start values
  always @(negedge pins.rp_n) begin
    sr = 8'h80;
    mode = FM_ARRAY;
  end
  // status frozen at strobe fall; reserved bits wander on purpose
  always @(posedge rd_on) begin
    rsv = rsv + 3'h1;
    held = {sr[7:3], rsv};
  end
  // released lines show the inverse of the last value
  always @(dq)
    if (rd_on) last = dq;
  always @* begin
    if (!rd_on) dq = ~last;
    else if (mode == FM_ID) dq = pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
    else if (mode == FM_ARRAY) dq = pins.addr[7:0] ^ pins.addr[15:8];
    else dq = held;
  end
endmodule // fch_flash_model

// File: verif/fch_host_checker.sv
// concurrent checks on the flash command host ports
`timescale 1ns/10ps
module fch_host_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fch_pkg::fch_axi_req_type axi_req,
  input wire fch_pkg::fch_axi_rsp_type axi_rsp,
  input wire logic [7:0] flash_dq_i,
  input wire fch_pkg::fch_pins_type flash_pins
);
  import fch_pkg::*;
  wire we_n = flash_pins.we_n;
  wire ce_n = flash_pins.ce_n;
  wire oe_n = flash_pins.oe_n;
  wire [7:0] dq_o = flash_pins.dq_o;
  wire ctrl_arr = axi_req.awvalid && axi_req.wvalid && !axi_rsp.awready && !axi_rsp.bvalid
    && axi_req.awaddr == 4'h0 && axi_req.wdata[3:0] == 4'h0 && axi_req.wstrb[0];
  logic [7:0] prev_q;
  logic data_q;
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // helper
  // data_q marks a write-data cycle, whose byte is no command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 8'h00;
      data_q <= 1'b0;
    end else if ($rose(we_n)) begin
      prev_q <= data_q ? 8'h00 : dq_o; // a data byte is no command
      data_q <= !data_q && (dq_o == 8'h40 || dq_o == 8'h10);
    end
  end
  // ==========
  // assertions
  cmd_frame_a: assert property (!we_n |-> oe_n && !ce_n && flash_pins.dq_oe)
    else $error("strobe without command framing");
  latch_hold_a: assert property ($rose(we_n) |-> !ce_n && $stable(dq_o))
    else $error("data moved at strobe rise");
  code_valid_a: assert property ($rose(we_n) && !data_q |-> dq_o inside {8'hff, 8'h90,
      8'h70, 8'h50, 8'h20, 8'hd0, 8'hb0, 8'h40, 8'h10}) else $error("unlisted code sent");
  erase_pair_a: assert property ($rose(we_n) && !data_q && dq_o == 8'h20 |->
      ##2 !we_n && dq_o == 8'hd0) else $error("erase setup without confirm");
  write_pair_a: assert property ($rose(we_n) && !data_q && dq_o == 8'h40 |->
      ##2 !we_n && flash_pins.addr == $past(flash_pins.addr, 2)) else $error("no data cycle");
  go_poll_a: assert property ($rose(we_n) && dq_o == 8'hd0 && prev_q == 8'h20 |->
      ##2 !ce_n && !oe_n && we_n) else $error("no poll after confirm");
  status_read_a: assert property ($rose(we_n) && !data_q && dq_o inside {8'h70, 8'h90} |->
      ##2 !ce_n && !oe_n) else $error("no read after read command");
  array_cmd_a: assert property (ctrl_arr |-> ##[1:6] !we_n && dq_o == 8'hff)
    else $error("array read code not sent");
endmodule // fch_host_checker
bind fch_host fch_host_checker chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .flash_dq_i(flash_dq_i), .flash_pins(flash_pins));

// File: verif/fch_host_bench.sv
// bench: flash host with device model, random and corner sequences
`timescale 1ns/10ps
`include "fch_consts.svh"
module fch_host_bench;
  import fch_pkg::*;
  localparam logic [7:0] MAKER = 8'h2d; // arbitrary value
  localparam logic [7:0] DEV = 8'h3c; // arbitrary value
  logic aclk, aresetn;
  fch_axi_req_type axi_req;
  fch_axi_rsp_type axi_rsp;
  fch_pins_type flash_pins;
  logic [7:0] flash_dq, e;
  logic [31:0] st, rd;
  logic [1:0] resp;
  logic [19:0] a;
  int n_mismatch = 0, n_tests = 0;
  integer seed = 32'h3439;
  fch_host uut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .flash_dq_i(flash_dq), .flash_pins(flash_pins));
  fch_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) flash (.pins(flash_pins),
    .dq(flash_dq));
  // ==========
  // clock, compare, bus tasks
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [7:0] arr_byte(input logic [19:0] ad);
    return ad[7:0] ^ ad[15:8];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // an edge first, so no signal is assigned twice in one step
  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] wd, output logic [1:0] rs);
    @(posedge aclk);
    axi_req.awaddr <= ad;
    axi_req.wdata <= wd;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) break;
    end
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    axi_req.araddr <= ad;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) break;
    end
    dt = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
  // order one operation and poll until the host is idle
  task automatic do_op(input logic [3:0] op, input logic [19:0] ad, input logic [7:0] wd);
    axi_wr(`FCH_REG_ADDR, 32'(ad), resp);
    axi_wr(`FCH_REG_WDATA, 32'(wd), resp);
    axi_wr(`FCH_REG_CTRL, 32'(op), resp);
    st = 32'h1;
    while (st[0] !== 1'b0) axi_rd(`FCH_REG_STATUS, st, resp);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog, far beyond the expected run length
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end
  // ==========
  // main sequence
  initial begin
    aresetn = 1'b0;
    axi_req = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) begin
      a = 20'($random(seed));
      do_op(FCH_OP_READ, a, 8'h00);
      check(32'(st[23:16]), 32'(arr_byte(a)));
    end
    do_op(FCH_OP_IDENTIFY, 20'h00001, 8'h00);
    check(32'(st[23:16]), 32'(DEV));
    do_op(FCH_OP_READ, 20'h00000, 8'h00);
    check(32'(st[23:16]), 32'(MAKER));
    do_op(FCH_OP_READ_STATUS, 20'h0, 8'h00);
    check(32'(st[15:8] & 8'hf8), 32'h80);
    do_op(FCH_OP_READ_ARRAY, 20'h0, 8'h00);
    do_op(FCH_OP_READ, a, 8'h00);
    check(32'(st[23:16]), 32'(arr_byte(a)));
    // write on a quick sequencer, erase on a slow one, each with and without a fault
    for (int i = 0; i < 4; i++) begin
      flash.busy_ns = i[0] ? 2000 : 40;
      flash.fail_next = i[1];
      e = i[1] ? (i[0] ? 8'ha0 : 8'h90) : 8'h80;
      do_op(i[0] ? FCH_OP_ERASE : FCH_OP_WRITE, 20'($random(seed)), 8'($random(seed)));
      check(32'(st[15:8] & 8'hf8), 32'(e));
      do_op(FCH_OP_READ, a, 8'h00);
      check(32'(st[23:16] & 8'hf8), 32'(e));
      do_op(FCH_OP_READ_STATUS, 20'h0, 8'h00);
      check(32'(st[15:8] & 8'hf8), 32'(e));
      do_op(FCH_OP_CLEAR, 20'h0, 8'h00);
      do_op(FCH_OP_READ_STATUS, 20'h0, 8'h00);
      check(32'(st[15:8] & 8'hf8), 32'h80);
    end
    // missing supply is sticky and blocks writes until cleared
    flash.supply_ok = 1'b0;
    do_op(FCH_OP_ERASE, 20'h12345, 8'h00);
    check(32'(st[15:8] & 8'hf8), 32'h88);
    flash.supply_ok = 1'b1;
    do_op(FCH_OP_WRITE, 20'h00010, 8'h5a);
    check(32'(st[1]), 32'h1);
    do_op(FCH_OP_CLEAR, 20'h0, 8'h00);
    do_op(FCH_OP_WRITE, 20'h00010, 8'h5a);
    check(32'(st[1]), 32'h0);
    // reset pin drops a sticky fault and restores array reads
    flash.fail_next = 1'b1;
    do_op(FCH_OP_WRITE, a, 8'h3c);
    do_op(FCH_OP_RESET, 20'h0, 8'h00);
    do_op(FCH_OP_READ, a, 8'h00);
    check(32'(st[23:16]), 32'(arr_byte(a)));
    do_op(FCH_OP_READ_STATUS, 20'h0, 8'h00);
    check(32'(st[15:8] & 8'hf8), 32'h80);
    // suspend shows ready and suspended; identify is ignored while suspended
    do_op(FCH_OP_SUSPEND, 20'h0, 8'h00);
    check(32'(st[15:8] & 8'hf8), 32'hc0);
    do_op(FCH_OP_IDENTIFY, 20'h00001, 8'h00);
    check(32'(st[23:16] & 8'hf8), 32'hc0);
    do_op(FCH_OP_RESUME, 20'h0, 8'h00);
    do_op(FCH_OP_READ_STATUS, 20'h0, 8'h00);
    check(32'(st[15:8] & 8'hf8), 32'h80);
    do_op(4'hc, 20'h0, 8'h00);
    check(32'(st[1]), 32'h1);
    // reset in mid-run: host status word back to zero, refusal dropped
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`FCH_REG_STATUS, rd, resp);
    check(rd, 32'h0);
    // register map edges
    axi_wr(`FCH_REG_STATUS, 32'h0, resp);
    check(32'(resp), 32'(`FCH_RESP_SLVERR));
    axi_rd(4'h2, rd, resp);
    check(32'(resp), 32'(`FCH_RESP_SLVERR));
    axi_wr(`FCH_REG_ADDR, {12'hfff, a}, resp);
    axi_rd(`FCH_REG_ADDR, rd, resp);
    check(rd, 32'(a));
    final_report();
  end
endmodule // fch_host_bench
